// file: design/uvfr_ctrl.sv
// Under-voltage fault response and restart controller
// Functional notes
// - Response 00: output keeps running while the fault is reported.
// - Response 01: run for the delay, then retry handling if fault stays.
// - Response 10: output off at once, then retry handling.
// - Response 11: output off only while fault present, resumes after.
// - Latched fault clears on status bit clear, clear-faults or reset.
// - Off-then-on command of the output clears the latched fault.
// - Retry field 000: no restart, output stays off until cleared.
// - Retry 001..110: that many restarts, then latched off.
// - Restart interval is two to the power of the delay code times the delay unit.
// - Retry 111: restart forever until commanded off or shut down.
// - Delay codes 4..7 give 16, 32, 64, 128 units.
// - Delay unit length comes from a separate configuration input.
// - Response byte serves under-voltage only, at its own command code.
module uvfr_ctrl (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic link_clk,
   input wire logic lk_cmd_valid,
   input wire logic lk_cmd_write,
   input wire logic [7:0] lk_cmd_code,
   input wire logic [7:0] lk_cmd_wdata,
   output logic lk_cmd_ready,
   output logic [7:0] lk_rdata,
   output logic lk_rvalid,
   input wire logic on_off_pin,
   input wire logic uv_fault_in,
   input wire logic ext_shutdown,
   input wire logic [15:0] delay_unit_cycles,
   output logic out_enable,
   output logic uv_fault_latched
);
   // ******************************************************
   // Link domain: command decode and read answers
   // ******************************************************
   logic lk_take, lk_send;
   uvfr_pkg::uvfr_kind_t lk_kind;
   logic [7:0] lk_resp_q, lk_resp_d;
   logic lk_op_q, lk_op_d;
   logic [7:0] lk_rdata_q, lk_rdata_d;
   logic lk_rvalid_q, lk_rvalid_d;
   logic lk_flt_s1_q, lk_flt_s2_q;
   logic [uvfr_pkg::XFER_W-1:0] x_data;
   logic x_valid;
   logic flt_q, flt_d;

   always_comb begin
      lk_take = lk_cmd_valid & lk_cmd_ready;
      lk_send = 1'b0;
      lk_kind = uvfr_pkg::UVFR_K_RESP;
      lk_resp_d = lk_resp_q;
      lk_op_d = lk_op_q;
      lk_rdata_d = lk_rdata_q;
      lk_rvalid_d = 1'b0;
      if (lk_take && lk_cmd_write) begin
         case (lk_cmd_code)
            uvfr_pkg::CMD_UV_RESPONSE: begin
               lk_send = 1'b1;
               lk_kind = uvfr_pkg::UVFR_K_RESP;
               lk_resp_d = lk_cmd_wdata;
            end
            uvfr_pkg::CMD_OPERATION: begin
               lk_send = 1'b1;
               lk_kind = uvfr_pkg::UVFR_K_OP;
               lk_op_d = lk_cmd_wdata[uvfr_pkg::OP_ON_BIT];
            end
            uvfr_pkg::CMD_CLEAR_FAULTS: begin
               lk_send = 1'b1;
               lk_kind = uvfr_pkg::UVFR_K_CLEAR;
            end
            uvfr_pkg::CMD_STATUS_VOUT: begin
               lk_send = 1'b1;
               lk_kind = uvfr_pkg::UVFR_K_STATUS;
            end
            default: begin
            end
         endcase
      end else if (lk_take) begin
         lk_rvalid_d = 1'b1;
         case (lk_cmd_code)
            uvfr_pkg::CMD_UV_RESPONSE: lk_rdata_d = lk_resp_q;
            uvfr_pkg::CMD_OPERATION: lk_rdata_d = {lk_op_q, 7'h00};
            uvfr_pkg::CMD_STATUS_VOUT:
               lk_rdata_d = 8'(lk_flt_s2_q) << uvfr_pkg::STATUS_UV_BIT;
            default: lk_rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         lk_resp_q <= uvfr_pkg::RESP_RST;
         lk_op_q <= uvfr_pkg::OP_ON_RST;
         lk_rdata_q <= 8'h00;
         lk_rvalid_q <= 1'b0;
         lk_flt_s1_q <= 1'b0;
         lk_flt_s2_q <= 1'b0;
      end else begin
         lk_resp_q <= lk_resp_d;
         lk_op_q <= lk_op_d;
         lk_rdata_q <= lk_rdata_d;
         lk_rvalid_q <= lk_rvalid_d;
         lk_flt_s1_q <= flt_q;
         lk_flt_s2_q <= lk_flt_s1_q;
      end
   end

   assign lk_rdata = lk_rdata_q;
   assign lk_rvalid = lk_rvalid_q;

   uvfr_xfer #(
      .W(uvfr_pkg::XFER_W)
   ) u_xfer (
      .src_clk(link_clk),
      .dst_clk(ref_clk),
      .rst_b(rst_b),
      .src_send(lk_send),
      .src_data({lk_kind, lk_cmd_wdata}),
      .src_ready(lk_cmd_ready),
      .dst_valid(x_valid),
      .dst_data(x_data)
   );

   // ******************************************************
   // Core domain: commands, fault latch and attempts
   // ******************************************************
   logic pin_s1_q, pin_s2_q;
   logic [7:0] resp_q, resp_d;
   logic op_on_q, op_on_d;
   logic on_prev_q;
   logic cmd_on, on_rise, clear_ev, flt_set;
   logic [2:0] att_q, att_d;
   uvfr_pkg::uvfr_state_t state_q, state_d, shut_st;
   uvfr_pkg::uvfr_kind_t x_kind;
   uvfr_pkg::uvfr_resp_t resp_sel;
   logic [2:0] retry_f, dly_f;
   logic out_en_q, out_en_d;

   always_comb begin
      x_kind = uvfr_pkg::uvfr_kind_t'(x_data[uvfr_pkg::XFER_W-1 -: 2]);
      resp_d = resp_q;
      op_on_d = op_on_q;
      if (x_valid && x_kind == uvfr_pkg::UVFR_K_RESP) begin
         resp_d = x_data[7:0];
      end
      if (x_valid && x_kind == uvfr_pkg::UVFR_K_OP) begin
         op_on_d = x_data[uvfr_pkg::OP_ON_BIT];
      end
      resp_sel = uvfr_pkg::uvfr_resp_t'(resp_q[uvfr_pkg::RESP_HI:
                                               uvfr_pkg::RESP_LO]);
      retry_f = resp_q[uvfr_pkg::RETRY_HI:uvfr_pkg::RETRY_LO];
      dly_f = resp_q[uvfr_pkg::DLY_HI:uvfr_pkg::DLY_LO];
      cmd_on = pin_s2_q & op_on_q;
      on_rise = cmd_on & ~on_prev_q;
      clear_ev = (x_valid && x_kind == uvfr_pkg::UVFR_K_CLEAR) ||
         (x_valid && x_kind == uvfr_pkg::UVFR_K_STATUS &&
          x_data[uvfr_pkg::STATUS_UV_BIT]) || on_rise;
      flt_set = uv_fault_in & out_en_q;
      // Set wins over a clear in the same cycle
      flt_d = flt_set ? 1'b1 : (clear_ev ? 1'b0 : flt_q);
   end

   // ******************************************************
   // Delay timer: code selects a power of two of units
   // ******************************************************
   logic [uvfr_pkg::UNIT_W-1:0] unit_eff, unit_cnt_q, unit_cnt_d;
   logic [uvfr_pkg::TICK_W-1:0] mult, tick_q, tick_d;
   logic done;

   always_comb begin
      mult = uvfr_pkg::TICK_W'(1) << dly_f;
      unit_eff = (delay_unit_cycles == '0) ? uvfr_pkg::UNIT_W'(1) :
         delay_unit_cycles;
      done = (tick_q == mult);
      unit_cnt_d = unit_cnt_q;
      tick_d = tick_q;
      if (state_d != state_q) begin
         unit_cnt_d = '0;
         tick_d = '0;
      end else if (!done) begin
         if (unit_cnt_q == unit_eff - uvfr_pkg::UNIT_W'(1)) begin
            unit_cnt_d = '0;
            tick_d = tick_q + uvfr_pkg::TICK_W'(1);
         end else begin
            unit_cnt_d = unit_cnt_q + uvfr_pkg::UNIT_W'(1);
         end
      end
   end

   // ******************************************************
   // Response state machine
   // ******************************************************
   always_comb begin
      att_d = att_q;
      if (retry_f == uvfr_pkg::RETRY_NONE ||
          (att_q == 3'h0 && retry_f != uvfr_pkg::RETRY_FOREVER)) begin
         shut_st = uvfr_pkg::UVFR_LATCH;
      end else begin
         shut_st = uvfr_pkg::UVFR_WAIT;
      end
      state_d = state_q;
      if (!cmd_on) begin
         state_d = uvfr_pkg::UVFR_IDLE;
      end else begin
         case (state_q)
            uvfr_pkg::UVFR_IDLE: state_d = uvfr_pkg::UVFR_RUN;
            uvfr_pkg::UVFR_RUN: begin
               if (ext_shutdown) begin
                  state_d = uvfr_pkg::UVFR_LATCH;
               end else if (uv_fault_in) begin
                  case (resp_sel)
                     uvfr_pkg::UVFR_IGNORE: state_d = uvfr_pkg::UVFR_RUN;
                     uvfr_pkg::UVFR_DELAY: state_d = uvfr_pkg::UVFR_DLY;
                     uvfr_pkg::UVFR_RETRY: state_d = shut_st;
                     default: state_d = uvfr_pkg::UVFR_HOLD;
                  endcase
               end
            end
            uvfr_pkg::UVFR_DLY: begin
               if (ext_shutdown) begin
                  state_d = uvfr_pkg::UVFR_LATCH;
               end else if (!uv_fault_in) begin
                  state_d = uvfr_pkg::UVFR_RUN;
               end else if (done) begin
                  state_d = shut_st;
               end
            end
            uvfr_pkg::UVFR_WAIT: begin
               if (ext_shutdown) begin
                  state_d = uvfr_pkg::UVFR_LATCH;
               end else if (done) begin
                  state_d = uvfr_pkg::UVFR_RUN;
                  if (retry_f != uvfr_pkg::RETRY_FOREVER) begin
                     att_d = att_q - 3'h1;
                  end
               end
            end
            uvfr_pkg::UVFR_HOLD: begin
               if (ext_shutdown) begin
                  state_d = uvfr_pkg::UVFR_LATCH;
               end else if (!uv_fault_in) begin
                  state_d = uvfr_pkg::UVFR_RUN;
               end
            end
            uvfr_pkg::UVFR_LATCH: begin
               if (clear_ev) begin
                  state_d = uvfr_pkg::UVFR_RUN;
               end
            end
            default: state_d = uvfr_pkg::UVFR_IDLE;
         endcase
      end
      if (clear_ev || (x_valid && x_kind == uvfr_pkg::UVFR_K_RESP)) begin
         att_d = (x_valid && x_kind == uvfr_pkg::UVFR_K_RESP) ?
            x_data[uvfr_pkg::RETRY_HI:uvfr_pkg::RETRY_LO] : retry_f;
      end
      out_en_d = (state_d == uvfr_pkg::UVFR_RUN) ||
         (state_d == uvfr_pkg::UVFR_DLY);
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         resp_q <= uvfr_pkg::RESP_RST;
         op_on_q <= uvfr_pkg::OP_ON_RST;
         on_prev_q <= 1'b0;
         flt_q <= 1'b0;
         att_q <= 3'h0;
         state_q <= uvfr_pkg::UVFR_IDLE;
         unit_cnt_q <= '0;
         tick_q <= '0;
         out_en_q <= 1'b0;
      end else begin
         pin_s1_q <= on_off_pin;
         pin_s2_q <= pin_s1_q;
         resp_q <= resp_d;
         op_on_q <= op_on_d;
         on_prev_q <= cmd_on;
         flt_q <= flt_d;
         att_q <= att_d;
         state_q <= state_d;
         unit_cnt_q <= unit_cnt_d;
         tick_q <= tick_d;
         out_en_q <= out_en_d;
      end
   end

   assign out_enable = out_en_q;
   assign uv_fault_latched = flt_q;

   // ******************************************************
   // Checks
   // ******************************************************
   logic [uvfr_pkg::SPAN_W-1:0] wcnt_q, span;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wcnt_q <= '0;
      end else begin
         wcnt_q <= (state_d != state_q) ? '0 : wcnt_q + 24'h000001;
      end
   end

   assign span = {8'h00, unit_eff} * {16'h0000, mult};

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   sequence s_run_fault;
      state_q == uvfr_pkg::UVFR_RUN && uv_fault_in && cmd_on && !ext_shutdown;
   endsequence

   property p_ignore_runs;
      s_run_fault and resp_sel == uvfr_pkg::UVFR_IGNORE |=> out_en_q;
   endproperty
   a_ignore_runs: assert property (p_ignore_runs)
      else $error("ignore mode dropped the output");

   property p_delay_runs;
      s_run_fault and resp_sel == uvfr_pkg::UVFR_DELAY |=>
         state_q == uvfr_pkg::UVFR_DLY && out_en_q;
   endproperty
   a_delay_runs: assert property (p_delay_runs)
      else $error("delay mode did not keep running");

   property p_retry_off;
      s_run_fault and resp_sel == uvfr_pkg::UVFR_RETRY |=> !out_en_q;
   endproperty
   a_retry_off: assert property (p_retry_off)
      else $error("shutdown mode left output on");

   property p_hold_resume;
      state_q == uvfr_pkg::UVFR_HOLD && !uv_fault_in && cmd_on &&
         !ext_shutdown |=> out_en_q;
   endproperty
   a_hold_resume: assert property (p_hold_resume)
      else $error("output did not resume after fault went away");

   property p_clear;
      clear_ev && !flt_set |=> !uv_fault_latched;
   endproperty
   a_clear: assert property (p_clear)
      else $error("latched fault not cleared");

   property p_on_reload;
      on_rise && !x_valid |=> att_q == $past(retry_f);
   endproperty
   a_on_reload: assert property (p_on_reload)
      else $error("attempt count not reloaded on command on");

   property p_no_retry;
      s_run_fault and resp_sel == uvfr_pkg::UVFR_RETRY &&
         retry_f == uvfr_pkg::RETRY_NONE |=>
         state_q == uvfr_pkg::UVFR_LATCH;
   endproperty
   a_no_retry: assert property (p_no_retry)
      else $error("zero retry setting did not latch off");

   property p_count_down;
      state_q == uvfr_pkg::UVFR_WAIT && done && cmd_on && !ext_shutdown &&
         !clear_ev && !x_valid && retry_f != uvfr_pkg::RETRY_FOREVER |=>
         att_q == $past(att_q) - 3'h1;
   endproperty
   a_count_down: assert property (p_count_down)
      else $error("restart did not use up one attempt");

   property p_interval;
      state_q == uvfr_pkg::UVFR_WAIT && state_d == uvfr_pkg::UVFR_RUN |->
         wcnt_q == span;
   endproperty
   a_interval: assert property (p_interval)
      else $error("restart interval length wrong");

   property p_cmd_off;
      !cmd_on |=> state_q == uvfr_pkg::UVFR_IDLE ##0 !out_en_q;
   endproperty
   a_cmd_off: assert property (p_cmd_off)
      else $error("command off did not stop the output");

   c_exhaust: cover property (state_q == uvfr_pkg::UVFR_WAIT ##1
      state_q == uvfr_pkg::UVFR_RUN ##[1:1000]
      state_q == uvfr_pkg::UVFR_LATCH);
   c_delay_expire: cover property (state_q == uvfr_pkg::UVFR_DLY && done);
   c_hold_resume: cover property (state_q == uvfr_pkg::UVFR_HOLD ##1
      state_q == uvfr_pkg::UVFR_RUN);
endmodule : uvfr_ctrl

// file: design/uvfr_xfer.sv
// Toggle handshake carrying one word from the link clock to the core clock
module uvfr_xfer #(
   parameter int W = 10
) (
   input wire logic src_clk,
   input wire logic dst_clk,
   input wire logic rst_b,
   input wire logic src_send,
   input wire logic [W-1:0] src_data,
   output logic src_ready,
   output logic dst_valid,
   output logic [W-1:0] dst_data
);
   // ******************************************************
   // Source side
   // ******************************************************
   logic req_q, req_d;
   logic ack_s1_q, ack_s2_q;
   logic ready_q, ready_d;
   logic [W-1:0] hold_q, hold_d;
   logic ack_q;

   always_comb begin
      req_d = req_q;
      hold_d = hold_q;
      ready_d = ready_q;
      if (src_send && ready_q) begin
         req_d = ~req_q;
         hold_d = src_data;
         ready_d = 1'b0;
      end else if (!ready_q && (ack_s2_q == req_q)) begin
         ready_d = 1'b1;
      end
   end

   always_ff @(posedge src_clk or negedge rst_b) begin
      if (!rst_b) begin
         req_q <= 1'b0;
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
         ready_q <= 1'b1;
         hold_q <= '0;
      end else begin
         req_q <= req_d;
         ack_s1_q <= ack_q;
         ack_s2_q <= ack_s1_q;
         ready_q <= ready_d;
         hold_q <= hold_d;
      end
   end

   assign src_ready = ready_q;

   // ******************************************************
   // Destination side
   // ******************************************************
   logic req_s1_q, req_s2_q;
   logic valid_d, valid_q;
   logic [W-1:0] data_d, data_q;

   always_comb begin
      valid_d = req_s2_q ^ ack_q;
      data_d = valid_d ? hold_q : data_q;
   end

   always_ff @(posedge dst_clk or negedge rst_b) begin
      if (!rst_b) begin
         req_s1_q <= 1'b0;
         req_s2_q <= 1'b0;
         ack_q <= 1'b0;
         valid_q <= 1'b0;
         data_q <= '0;
      end else begin
         req_s1_q <= src_req_pass(req_q);
         req_s2_q <= req_s1_q;
         ack_q <= req_s2_q;
         valid_q <= valid_d;
         data_q <= data_d;
      end
   end

   function automatic logic src_req_pass(input logic v);
      return v;
   endfunction : src_req_pass

   assign dst_valid = valid_q;
   assign dst_data = data_q;
endmodule : uvfr_xfer

// file: inc/uvfr_pkg.sv
// Constants and types for the under-voltage fault response controller
package uvfr_pkg;
   // ******************************************************
   // Command codes seen on the link
   // ******************************************************
   localparam logic [7:0] CMD_OPERATION = 8'h01;
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_UV_RESPONSE = 8'h45;
   localparam logic [7:0] CMD_STATUS_VOUT = 8'h7A;

   // ******************************************************
   // Field positions and reset values
   // ******************************************************
   localparam int OP_ON_BIT = 7;
   localparam int STATUS_UV_BIT = 4;
   localparam int RESP_HI = 7;
   localparam int RESP_LO = 6;
   localparam int RETRY_HI = 5;
   localparam int RETRY_LO = 3;
   localparam int DLY_HI = 2;
   localparam int DLY_LO = 0;
   localparam logic [7:0] RESP_RST = 8'h80;
   localparam logic OP_ON_RST = 1'b1;
   localparam logic [2:0] RETRY_NONE = 3'h0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;

   // ******************************************************
   // Widths
   // ******************************************************
   localparam int UNIT_W = 16;
   localparam int TICK_W = 8;
   localparam int SPAN_W = 24;
   localparam int XFER_W = 10;

   typedef enum logic [1:0] {
      UVFR_IGNORE = 2'b00,
      UVFR_DELAY = 2'b01,
      UVFR_RETRY = 2'b10,
      UVFR_HOLD_OFF = 2'b11
   } uvfr_resp_t;

   typedef enum logic [1:0] {
      UVFR_K_RESP = 2'b00,
      UVFR_K_CLEAR = 2'b01,
      UVFR_K_STATUS = 2'b10,
      UVFR_K_OP = 2'b11
   } uvfr_kind_t;

   typedef enum logic [2:0] {
      UVFR_IDLE = 3'b000,
      UVFR_RUN = 3'b001,
      UVFR_DLY = 3'b010,
      UVFR_WAIT = 3'b011,
      UVFR_HOLD = 3'b100,
      UVFR_LATCH = 3'b101
   } uvfr_state_t;
endpackage : uvfr_pkg

// file: test/tb_uvfr_ctrl.sv
// Self-checking bench for the under-voltage fault response controller
module tb_uvfr_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst_b = 1'b0;
   logic on_off_pin = 1'b1;
   logic uv_fault_in = 1'b0;
   logic ext_shutdown = 1'b0;
   logic [15:0] delay_unit_cycles = 16'h0001;
   logic lk_cmd_valid, lk_cmd_write, lk_cmd_ready, lk_rvalid;
   logic [7:0] lk_cmd_code, lk_cmd_wdata, lk_rdata;
   logic out_enable, uv_fault_latched;
   int errors = 0;
   int comparisons = 0;

   uvfr_ctrl i_uvfr_ctrl (.ref_clk(ref_clk), .rst_b(rst_b),
      .link_clk(link_clk), .lk_cmd_valid(lk_cmd_valid),
      .lk_cmd_write(lk_cmd_write), .lk_cmd_code(lk_cmd_code),
      .lk_cmd_wdata(lk_cmd_wdata), .lk_cmd_ready(lk_cmd_ready),
      .lk_rdata(lk_rdata), .lk_rvalid(lk_rvalid),
      .on_off_pin(on_off_pin), .uv_fault_in(uv_fault_in),
      .ext_shutdown(ext_shutdown), .delay_unit_cycles(delay_unit_cycles),
      .out_enable(out_enable), .uv_fault_latched(uv_fault_latched));
   uvfr_host i_uvfr_host (.link_clk(link_clk), .lk_cmd_ready(lk_cmd_ready),
      .lk_rdata(lk_rdata), .lk_rvalid(lk_rvalid),
      .lk_cmd_valid(lk_cmd_valid), .lk_cmd_write(lk_cmd_write),
      .lk_cmd_code(lk_cmd_code), .lk_cmd_wdata(lk_cmd_wdata));

   always #50 ref_clk = ~ref_clk;
   always #3 link_clk = ~link_clk;

   // ****************************************
   // Helpers
   // ****************************************
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : conclude
   task automatic chk8(input string n, input logic [7:0] e,
      input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk8
   task automatic chkr(input string n, input int lo, input int hi,
      input int g);
      comparisons++;
      if (g < lo || g > hi) begin
         errors++;
         $display("MISMATCH %s expected %0d..%0d seen %0d", n, lo, hi, g);
      end
   endtask : chkr
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : step
   task automatic wr(input logic [7:0] c, input logic [7:0] v);
      logic [7:0] d;
      i_uvfr_host.xfer(1'b1, c, v, d);
      chk8("wr taken", 8'h00, d);
      step(8);
   endtask : wr
   task automatic rd(input logic [7:0] c, output logic [7:0] d);
      i_uvfr_host.xfer(1'b0, c, 8'h00, d);
   endtask : rd
   task automatic fault(input logic v);
      @(posedge ref_clk);
      uv_fault_in <= v;
   endtask : fault
   task automatic wait_oe(input logic v, input int lim, output int t);
      t = 0;
      while (out_enable !== v && t < lim) begin
         @(posedge ref_clk);
         #1;
         t++;
      end
   endtask : wait_oe
   // Counts output restarts and the low time before the first one
   task automatic watch(input int n, output int r, output int off);
      logic p;
      r = 0;
      off = 0;
      #1 p = out_enable;
      repeat (n) begin
         @(posedge ref_clk);
         #1;
         if (out_enable === 1'b1 && p !== 1'b1) r++;
         if (r == 0 && out_enable !== 1'b1) off++;
         p = out_enable;
      end
   endtask : watch

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      logic [7:0] d;
      int t;
      wait_oe(1'b1, 10, t);
      chkr("start", 2, 9, t);
      rd(8'h45, d);
      chk8("resp rst", 8'h80, d);
      rd(8'h01, d);
      chk8("op rst", 8'h80, d);
      rd(8'h7A, d);
      chk8("stat rst", 8'h00, d);
      wr(8'h20, 8'h5A);
      rd(8'h20, d);
      chk8("unknown", 8'h00, d);
      wr(8'h45, 8'h6D);
      rd(8'h45, d);
      chk8("resp rw", 8'h6D, d);
   endtask : t_reset
   task automatic t_ignore();
      logic [7:0] d;
      int r, off;
      wr(8'h45, 8'h00);
      fault(1'b1);
      watch(40, r, off);
      chkr("ignore", 0, 0, off);
      fault(1'b0);
      rd(8'h7A, d);
      chk8("stat uv", 8'h10, d & 8'h10);
      wr(8'h03, 8'h00);
      chk8("clr", 8'h00, {7'h00, uv_fault_latched});
   endtask : t_ignore
   task automatic t_latch();
      int t, r, off;
      wr(8'h45, 8'h80);
      fault(1'b1);
      wait_oe(1'b0, 5, t);
      chkr("shut", 1, 4, t);
      fault(1'b0);
      watch(60, r, off);
      chkr("no retry", 0, 0, r);
      wr(8'h7A, 8'h10);
      wait_oe(1'b1, 12, t);
      chkr("bit clr", 0, 11, t);
   endtask : t_latch
   task automatic t_delay();
      int t, r, off;
      @(posedge ref_clk);
      delay_unit_cycles <= 16'h0002;
      wr(8'h45, 8'h42);
      fault(1'b1);
      step(4);
      fault(1'b0);
      watch(20, r, off);
      chkr("short", 0, 0, off);
      fault(1'b1);
      wait_oe(1'b0, 14, t);
      chkr("delay", 8, 13, t);
      watch(30, r, off);
      chkr("dly latch", 0, 0, r);
      fault(1'b0);
      wr(8'h03, 8'h00);
   endtask : t_delay
   task automatic t_hold();
      int t, r, off;
      wr(8'h45, 8'hC0);
      fault(1'b1);
      wait_oe(1'b0, 5, t);
      chkr("hold off", 1, 4, t);
      watch(20, r, off);
      chkr("hold stay", 0, 0, r);
      fault(1'b0);
      wait_oe(1'b1, 8, t);
      chkr("hold on", 1, 7, t);
      wr(8'h03, 8'h00);
   endtask : t_hold
   task automatic t_retry();
      logic [2:0] rf;
      int span, t, r, off;
      for (int i = 0; i < 8; i++) begin
         rf = 3'(i % 6 + 1);
         span = 2 << i;
         wr(8'h45, {2'b10, rf, 3'(i)});
         fault(1'b1);
         wait_oe(1'b0, 5, t);
         watch(int'(rf) * (span + 10) + 30, r, off);
         chkr("gap", span - 1, span + 3, off);
         chkr("tries", rf, rf, r);
         chk8("latch", 8'h01, {7'h00, uv_fault_latched});
         fault(1'b0);
         wr(8'h03, 8'h00);
         wait_oe(1'b1, 12, t);
         chkr("reon", 0, 11, t);
      end
   endtask : t_retry
   task automatic t_forever();
      int t, r, off;
      @(posedge ref_clk);
      delay_unit_cycles <= 16'h0001;
      wr(8'h45, 8'hB8);
      fault(1'b1);
      watch(200, r, off);
      chkr("endless", 10, 200, r);
      @(posedge ref_clk);
      on_off_pin <= 1'b0;
      // Pin passes two sync stages before the output is forced off
      step(3);
      watch(40, r, off);
      chkr("pin off", 0, 0, r);
      fault(1'b0);
      @(posedge ref_clk);
      on_off_pin <= 1'b1;
      watch(20, r, off);
      chkr("pin on", 1, 1, r);
      fault(1'b1);
      @(posedge ref_clk);
      ext_shutdown <= 1'b1;
      step(3);
      ext_shutdown <= 1'b0;
      watch(60, r, off);
      chkr("ext stop", 0, 0, r);
      fault(1'b0);
      wr(8'h01, 8'h00);
      wr(8'h01, 8'h80);
      wait_oe(1'b1, 12, t);
      chkr("op cycle", 0, 11, t);
      chk8("op clr", 8'h00, {7'h00, uv_fault_latched});
   endtask : t_forever

   initial begin
      repeat (12) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_reset();
      t_ignore();
      t_latch();
      t_delay();
      t_hold();
      t_retry();
      t_forever();
      conclude();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      conclude();
   end
endmodule : tb_uvfr_ctrl

// file: test/uvfr_host.sv
// Host-side link controller model issuing single-byte commands
module uvfr_host (
   input wire logic link_clk,
   input wire logic lk_cmd_ready,
   input wire logic [7:0] lk_rdata,
   input wire logic lk_rvalid,
   output logic lk_cmd_valid,
   output logic lk_cmd_write,
   output logic [7:0] lk_cmd_code,
   output logic [7:0] lk_cmd_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      lk_cmd_valid = 1'b0;
      lk_cmd_write = 1'b0;
      lk_cmd_code = 8'h00;
      lk_cmd_wdata = 8'h00;
   end
   // Request held until taken; released bus shows inverted values
   task automatic xfer(input logic wr, input logic [7:0] code,
      input logic [7:0] wd, output logic [7:0] rd);
      int n;
      n = 0;
      rd = 8'hXX;
      @(posedge link_clk);
      lk_cmd_valid <= 1'b1;
      lk_cmd_write <= wr;
      lk_cmd_code <= code;
      lk_cmd_wdata <= wd;
      @(posedge link_clk);
      while (lk_cmd_ready !== 1'b1 && n < 500) begin
         @(posedge link_clk);
         n++;
      end
      // Write answer: 00 when taken, unknown when the wait ran out
      rd = (lk_cmd_ready === 1'b1) ? 8'h00 : 8'hXX;
      lk_cmd_valid <= 1'b0;
      lk_cmd_code <= ~code;
      lk_cmd_wdata <= ~wd;
      if (!wr) begin
         @(posedge link_clk);
         rd = (lk_rvalid === 1'b1) ? lk_rdata : 8'hXX;
      end
   endtask : xfer
endmodule : uvfr_host
